// >>> core/tcff_top.sv
/*
 * trigger configuration register and feature fault flag register, with
 * trigger source selection and polarity handling.
 * assumes a simple single-cycle register port from the serial bus link
 * layer and feature value write strobes from the feature register bank.
 */
// What this block does
// - trigger register bit 0 reads 1, read-only: trigger control present.
// - trigger register bit 1 reads 0, read-only: no absolute control.
// - trigger register bit 6 reads 1; writes to it do nothing.
// - bit 7 picks hardware trigger polarity, 0 low, 1 high; resets to 1.
// - bits 8-10 pick source: ports 0-3 or code 7 software; resets 0.
// - bits 12-15 pick scheme: 0 programmable, 1 level; resets to 1.
// - external source allows schemes 0 and 1; software source only 0.
// - fault bit is 1 when its feature setting is in error.
// - fault bit is recomputed whenever its feature register is written.
// - fault set when setting is below minimum or above maximum.
// - out-of-range settings are still used for capture, not clamped.
// - fault bit 0 is the read-only brightness flag.
// - fault bit 7 is the read-only shutter flag.
// - fault bit 8 is the read-only gain flag.
// - fault bit 12 is the read-only trigger configuration flag.
// - bit 0 is the most significant bit of each word.
// - shutter valid from 1 to 4095, else shutter flag set.
// - gain valid 0-740 at 8-bit, 0-125 at 16-bit, else flagged.
`timescale 1ns/100ps
module tcff_top
   import tcff_pkg::*;
#(
   parameter logic [11:0] BRIGHT_MIN = BRIGHT_MIN_DEF,
   parameter logic [11:0] BRIGHT_MAX = BRIGHT_MAX_DEF
)
(
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RESET_N,
   // register port
   input  wire logic [11:0] REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   output logic             REG_RVALID,
   // feature value writes
   input  wire logic        BRIGHT_WR,
   input  wire logic [11:0] BRIGHT_VALUE,
   input  wire logic        SHUT_WR,
   input  wire logic [11:0] SHUT_VALUE,
   input  wire logic        GAIN_WR,
   input  wire logic [11:0] GAIN_VALUE,
   input  wire logic        PIXEL_DEPTH16,
   // trigger inputs
   input  wire logic [3:0]  TRIG_PIN,
   input  wire logic        SW_TRIGGER,
   // trigger outputs
   output logic             TRIG_ACTIVE,
   output logic             TRIG_START,
   output logic      [3:0]  EXPOSURE_SCHEME
);

   tcff_eval_if ev ();

   logic        pol_ff;
   logic [2:0]  src_ff;
   logic [3:0]  sch_ff;
   logic [3:0]  pin_meta_ff;
   logic [3:0]  pin_sync_ff;
   logic        act_ff;
   logic        start_ff;
   logic [31:0] rdata_ff;
   logic        rvalid_ff;
   logic        trig_sel;
   logic        trig_wr;
   logic        nxt_act;
   logic [31:0] trig_word;
   logic [31:0] fault_word;
   logic [31:0] nxt_rdata;
   logic        hit_trig;
   logic        hit_fault;

   // ********************************************************
   // address decode
   // ********************************************************
   assign hit_trig  = REG_ADDR == TRIG_CFG_OFS;
   assign hit_fault = REG_ADDR == FAULT_HI_OFS;
   assign trig_wr   = REG_WR && hit_trig;

   // ********************************************************
   // trigger configuration register
   // ********************************************************
   // only polarity, source and scheme store; fixed and reserved bits ignore writes
   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pol_ff <= TRG_POL_RST;
         src_ff <= TRG_SRC_RST;
         sch_ff <= TRG_SCH_RST;
      end
      else if (trig_wr)
      begin
         pol_ff <= REG_WDATA[TRG_POL_POS];
         src_ff <= REG_WDATA[TRG_SRC_HI:TRG_SRC_LO];
         sch_ff <= REG_WDATA[TRG_SCH_HI:TRG_SCH_LO];
      end
   end

   // bit 11 and bits 20-31 read zero; software must not rely on them
   always_comb
   begin
      trig_word                           = 32'h0000_0000;
      trig_word[TRG_PRESENT_POS]          = TRG_PRESENT_VAL;
      trig_word[TRG_ABS_POS]              = TRG_ABS_VAL;
      trig_word[TRG_ONOFF_POS]            = TRG_ONOFF_VAL;
      trig_word[TRG_POL_POS]              = pol_ff;
      trig_word[TRG_SRC_HI:TRG_SRC_LO]    = src_ff;
      trig_word[TRG_SCH_HI:TRG_SCH_LO]    = sch_ff;
   end

   // ********************************************************
   // fault flag register
   // ********************************************************
   always_comb
   begin
      fault_word                 = 32'h0000_0000;
      fault_word[FLT_BRIGHT_POS] = ev.bright_flag;
      fault_word[FLT_SHUT_POS]   = ev.shut_flag;
      fault_word[FLT_GAIN_POS]   = ev.gain_flag;
      fault_word[FLT_TRIG_POS]   = ev.trig_flag;
   end

   assign ev.bright_wr   = BRIGHT_WR;
   assign ev.bright_val  = BRIGHT_VALUE;
   assign ev.shut_wr     = SHUT_WR;
   assign ev.shut_val    = SHUT_VALUE;
   assign ev.gain_wr     = GAIN_WR;
   assign ev.gain_val    = GAIN_VALUE;
   assign ev.depth16     = PIXEL_DEPTH16;
   // fault sees the value being written, so it settles with the register
   assign ev.trig_wr     = trig_wr;
   assign ev.trig_src    = REG_WDATA[TRG_SRC_HI:TRG_SRC_LO];
   assign ev.trig_scheme = REG_WDATA[TRG_SCH_HI:TRG_SCH_LO];

   tcff_fault_eval #(
      .BRIGHT_MIN (BRIGHT_MIN),
      .BRIGHT_MAX (BRIGHT_MAX)
   ) u_eval (
      .MCLK    (MCLK),
      .RESET_N (RESET_N),
      .ev      (ev.eval)
   );

   // ********************************************************
   // read path
   // ********************************************************
   // unmapped offsets read zero
   assign nxt_rdata = hit_trig  ? trig_word :
                      hit_fault ? fault_word : 32'h0000_0000;

   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rdata_ff  <= 32'h0000_0000;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rvalid_ff <= REG_RD;
         if (REG_RD) rdata_ff <= nxt_rdata;
      end
   end

   // ********************************************************
   // trigger selection
   // ********************************************************
   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pin_meta_ff <= 4'h0;
         pin_sync_ff <= 4'h0;
      end
      else
      begin
         pin_meta_ff <= TRIG_PIN;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // reserved codes 4-6 select nothing; a bad scheme is still passed on
   assign trig_sel = (src_ff <= SRC_PORT_MAX) ? pin_sync_ff[src_ff[1:0]] : 1'b0;
   assign nxt_act  = (src_ff == SRC_SOFTWARE) ? SW_TRIGGER :
                     (src_ff <= SRC_PORT_MAX) ? (pol_ff ? trig_sel : ~trig_sel)
                                              : 1'b0;

   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         act_ff   <= 1'b0;
         start_ff <= 1'b0;
      end
      else
      begin
         act_ff   <= nxt_act;
         start_ff <= nxt_act && !act_ff;
      end
   end

   assign REG_RDATA       = rdata_ff;
   assign REG_RVALID      = rvalid_ff;
   assign TRIG_ACTIVE     = act_ff;
   assign TRIG_START      = start_ff;
   assign EXPOSURE_SCHEME = sch_ff;

endmodule

// >>> core/tcff_pkg.sv
/*
 * constants for the trigger configuration and feature fault flag bank:
 * offsets, field positions, reset values and range limits.
 * assumes msb-first bit numbering: printed bit n is vector index 31-n.
 */
package tcff_pkg;

   // ********************************************************
   // register offsets
   // ********************************************************
   localparam logic [11:0] FAULT_HI_OFS    = 12'h640;
   localparam logic [11:0] TRIG_CFG_OFS    = 12'h830;

   // ********************************************************
   // trigger configuration fields (vector indices)
   // ********************************************************
   localparam int          TRG_PRESENT_POS = 31;
   localparam int          TRG_ABS_POS     = 30;
   localparam int          TRG_ONOFF_POS   = 25;
   localparam int          TRG_POL_POS     = 24;
   localparam int          TRG_SRC_HI      = 23;
   localparam int          TRG_SRC_LO      = 21;
   localparam int          TRG_SCH_HI      = 19;
   localparam int          TRG_SCH_LO      = 16;

   localparam logic        TRG_PRESENT_VAL = 1'b1;
   localparam logic        TRG_ABS_VAL     = 1'b0;
   localparam logic        TRG_ONOFF_VAL   = 1'b1;
   localparam logic        TRG_POL_RST     = 1'b1;
   localparam logic [2:0]  TRG_SRC_RST     = 3'h0;
   localparam logic [3:0]  TRG_SCH_RST     = 4'h1;

   localparam logic [2:0]  SRC_PORT_MAX    = 3'h3;
   localparam logic [2:0]  SRC_SOFTWARE    = 3'h7;
   localparam logic [3:0]  SCHEME_PROG     = 4'h0;
   localparam logic [3:0]  SCHEME_LEVEL    = 4'h1;

   // ********************************************************
   // fault flag fields (vector indices)
   // ********************************************************
   localparam int          FLT_BRIGHT_POS  = 31;
   localparam int          FLT_SHUT_POS    = 24;
   localparam int          FLT_GAIN_POS    = 23;
   localparam int          FLT_TRIG_POS    = 19;
   localparam logic        FLT_RST         = 1'b0;

   // ********************************************************
   // feature value ranges (12-bit value fields)
   // ********************************************************
   localparam logic [11:0] SHUT_MIN        = 12'h001;
   localparam logic [11:0] SHUT_MAX        = 12'hfff;
   localparam logic [11:0] GAIN_MAX_8BIT   = 12'h2e4;
   localparam logic [11:0] GAIN_MAX_16BIT  = 12'h07d;
   localparam logic [11:0] BRIGHT_MIN_DEF  = 12'h000;
   localparam logic [11:0] BRIGHT_MAX_DEF  = 12'hfff;

endpackage

// >>> core/tcff_eval_if.sv
/*
 * carrier between the register bank and its fault evaluator.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface tcff_eval_if;
   logic        bright_wr;
   logic [11:0] bright_val;
   logic        shut_wr;
   logic [11:0] shut_val;
   logic        gain_wr;
   logic [11:0] gain_val;
   logic        depth16;
   logic        trig_wr;
   logic [2:0]  trig_src;
   logic [3:0]  trig_scheme;
   logic        bright_flag;
   logic        shut_flag;
   logic        gain_flag;
   logic        trig_flag;

   modport bank (output bright_wr, bright_val, shut_wr, shut_val, gain_wr, gain_val,
                 depth16, trig_wr, trig_src, trig_scheme,
                 input  bright_flag, shut_flag, gain_flag, trig_flag);
   modport eval (input  bright_wr, bright_val, shut_wr, shut_val, gain_wr, gain_val,
                 depth16, trig_wr, trig_src, trig_scheme,
                 output bright_flag, shut_flag, gain_flag, trig_flag);
endinterface

// >>> core/tcff_fault_eval.sv
/*
 * fault evaluator: one sticky-by-write flag per feature, recomputed on
 * every write of that feature's control value.
 * assumes write strobes are single-cycle and on the same clock.
 */
`timescale 1ns/100ps
module tcff_fault_eval
   import tcff_pkg::*;
#(
   parameter logic [11:0] BRIGHT_MIN = BRIGHT_MIN_DEF,
   parameter logic [11:0] BRIGHT_MAX = BRIGHT_MAX_DEF
)
(
   // clock and reset
   input  wire logic   MCLK,
   input  wire logic   RESET_N,
   // evaluator side of the carrier
   tcff_eval_if.eval   ev
);

   logic        bright_ff;
   logic        shut_ff;
   logic        gain_ff;
   logic        trig_ff;
   logic [11:0] gain_max;
   logic        bright_bad;
   logic        shut_bad;
   logic        gain_bad;
   logic        trig_bad;

   // ********************************************************
   // range checks
   // ********************************************************
   // the value is only flagged, never clamped: capture keeps using it
   assign bright_bad = (ev.bright_val < BRIGHT_MIN) || (ev.bright_val > BRIGHT_MAX);
   assign shut_bad   = (ev.shut_val < SHUT_MIN) || (ev.shut_val > SHUT_MAX);
   assign gain_max   = ev.depth16 ? GAIN_MAX_16BIT : GAIN_MAX_8BIT;
   assign gain_bad   = ev.gain_val > gain_max;
   // reserved source codes, unknown schemes and level scheme on software source
   assign trig_bad   = ((ev.trig_src > SRC_PORT_MAX) && (ev.trig_src != SRC_SOFTWARE))
                       || (ev.trig_scheme > SCHEME_LEVEL)
                       || ((ev.trig_src == SRC_SOFTWARE)
                           && (ev.trig_scheme != SCHEME_PROG));

   // ********************************************************
   // flags, updated only when their register is written
   // ********************************************************
   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         bright_ff <= FLT_RST;
         shut_ff   <= FLT_RST;
         gain_ff   <= FLT_RST;
         trig_ff   <= FLT_RST;
      end
      else
      begin
         if (ev.bright_wr) bright_ff <= bright_bad;
         if (ev.shut_wr)   shut_ff   <= shut_bad;
         if (ev.gain_wr)   gain_ff   <= gain_bad;
         if (ev.trig_wr)   trig_ff   <= trig_bad;
      end
   end

   assign ev.bright_flag = bright_ff;
   assign ev.shut_flag   = shut_ff;
   assign ev.gain_flag   = gain_ff;
   assign ev.trig_flag   = trig_ff;

endmodule

// >>> dv/tcff_chk.sv
/* checker for the trigger and fault flag bank.
   sees only the top ports; bound into every tcff_top. */
`timescale 1ns/100ps
module tcff_chk
   import tcff_pkg::*;
#(
   parameter logic [11:0] BRIGHT_MIN = BRIGHT_MIN_DEF,
   parameter logic [11:0] BRIGHT_MAX = BRIGHT_MAX_DEF
)
(
   // clock and reset
   input wire logic        MCLK,
   input wire logic        RESET_N,
   // register port
   input wire logic [11:0] REG_ADDR,
   input wire logic        REG_WR,
   input wire logic [31:0] REG_WDATA,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic        REG_RVALID,
   // feature writes
   input wire logic        BRIGHT_WR,
   input wire logic [11:0] BRIGHT_VALUE,
   input wire logic        SHUT_WR,
   input wire logic [11:0] SHUT_VALUE,
   input wire logic        GAIN_WR,
   input wire logic [11:0] GAIN_VALUE,
   input wire logic        PIXEL_DEPTH16,
   // trigger outputs
   input wire logic        TRIG_ACTIVE,
   input wire logic        TRIG_START
);
   // *****
   // causes at the inputs
   // *****
   wire       rd_trg  = REG_RD && (REG_ADDR == TRIG_CFG_OFS);
   wire       rd_flt  = REG_RD && (REG_ADDR == FAULT_HI_OFS);
   wire       trg_wr  = REG_WR && (REG_ADDR == TRIG_CFG_OFS);
   wire [2:0] w_src   = REG_WDATA[TRG_SRC_HI:TRG_SRC_LO];
   wire [3:0] w_sch   = REG_WDATA[TRG_SCH_HI:TRG_SCH_LO];
   wire       trg_bad = (w_src > SRC_PORT_MAX && w_src != SRC_SOFTWARE) || w_sch > SCHEME_LEVEL
                        || (w_src == SRC_SOFTWARE && w_sch != SCHEME_PROG);
   wire       sh_bad  = SHUT_VALUE < SHUT_MIN || SHUT_VALUE > SHUT_MAX;
   wire       g_bad   = GAIN_VALUE > (PIXEL_DEPTH16 ? GAIN_MAX_16BIT : GAIN_MAX_8BIT);
   wire       b_bad   = BRIGHT_VALUE < BRIGHT_MIN || BRIGHT_VALUE > BRIGHT_MAX;

   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   a_trig_fixed_bits :
      assert property (rd_trg |=> REG_RVALID && REG_RDATA[31:30] == 2'b10 && REG_RDATA[25])
      else $error("fixed trigger bits wrong");
   a_trig_reserved :
      assert property (rd_trg |=> REG_RDATA[29:26] == 4'h0 && REG_RDATA[15:12] == 4'h0)
      else $error("reserved trigger bits set");
   a_fault_unused :
      assert property (rd_flt |=> (REG_RDATA & 32'h7e77_ffff) == 32'h0)
      else $error("unused fault bit set");
   a_shut_flag :
      assert property (SHUT_WR ##1 rd_flt |=> REG_RDATA[FLT_SHUT_POS] == $past(sh_bad, 2))
      else $error("shutter flag wrong");
   a_gain_flag :
      assert property (GAIN_WR ##1 rd_flt |=> REG_RDATA[FLT_GAIN_POS] == $past(g_bad, 2))
      else $error("gain flag wrong");
   a_bright_flag :
      assert property (BRIGHT_WR ##1 rd_flt |=> REG_RDATA[FLT_BRIGHT_POS] == $past(b_bad, 2))
      else $error("brightness flag wrong");
   a_trig_flag :
      assert property (trg_wr ##1 rd_flt |=> REG_RDATA[FLT_TRIG_POS] == $past(trg_bad, 2))
      else $error("trigger flag wrong");
   a_start_pulse :
      assert property (TRIG_START |-> TRIG_ACTIVE && !$past(TRIG_ACTIVE))
      else $error("start pulse without rising trigger");
endmodule

bind tcff_top tcff_chk #(.BRIGHT_MIN(BRIGHT_MIN), .BRIGHT_MAX(BRIGHT_MAX)) u_chk (
   .MCLK          (MCLK),
   .RESET_N       (RESET_N),
   .REG_ADDR      (REG_ADDR),
   .REG_WR        (REG_WR),
   .REG_WDATA     (REG_WDATA),
   .REG_RD        (REG_RD),
   .REG_RDATA     (REG_RDATA),
   .REG_RVALID    (REG_RVALID),
   .BRIGHT_WR     (BRIGHT_WR),
   .BRIGHT_VALUE  (BRIGHT_VALUE),
   .SHUT_WR       (SHUT_WR),
   .SHUT_VALUE    (SHUT_VALUE),
   .GAIN_WR       (GAIN_WR),
   .GAIN_VALUE    (GAIN_VALUE),
   .PIXEL_DEPTH16 (PIXEL_DEPTH16),
   .TRIG_ACTIVE   (TRIG_ACTIVE),
   .TRIG_START    (TRIG_START)
);

// >>> dv/tcff_host.sv
/* host and trigger source model for the bank.
   tasks are called just after a rising MCLK edge. */
`timescale 1ns/100ps
module tcff_host
   import tcff_pkg::*;
(
   // clock
   input wire logic         MCLK,
   // register port
   output logic      [11:0] REG_ADDR,
   output logic             REG_WR,
   output logic      [31:0] REG_WDATA,
   output logic             REG_RD,
   input  wire logic [31:0] REG_RDATA,
   input  wire logic        REG_RVALID,
   // trigger sources
   output logic      [3:0]  TRIG_PIN,
   output logic             SW_TRIGGER
);
   // software drops unused fields before looking at a word
   localparam logic [31:0] KEEP_TRG = 32'hffef_f000;
   localparam logic [31:0] KEEP_FLT = 32'h8188_0000;

   initial
   begin
      REG_ADDR = 12'h000;
      REG_WR = 1'b0;
      REG_WDATA = 32'h0;
      REG_RD = 1'b0;
      TRIG_PIN = 4'h0;
      SW_TRIGGER = 1'b0;
   end

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge MCLK);
      REG_WR <= 1'b0;
      // released data flips so stale values are never trusted
      REG_WDATA <= ~d;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge MCLK);
      REG_RD <= 1'b0;
      @(posedge MCLK);
      ok = REG_RVALID;
      d = REG_RDATA & ((a == TRIG_CFG_OFS) ? KEEP_TRG : (a == FAULT_HI_OFS) ? KEEP_FLT : '1);
   endtask

   task automatic pins(input logic [3:0] v);
      TRIG_PIN <= v;
   endtask

   task automatic sw(input logic v);
      SW_TRIGGER <= v;
   endtask
endmodule

// >>> dv/tb_top.sv
/* self-checking bench for the trigger and fault flag bank.
   host model drives the register port and trigger pins. */
`timescale 1ns/100ps
module tb_top
   import tcff_pkg::*;
;
   localparam logic [11:0] BMIN = 12'h010;
   localparam logic [11:0] BMAX = 12'hf00;
   localparam logic [11:0] CORNER [12] = '{12'h00f, 12'h000, 12'h2e4, 12'h010, 12'h001,
      12'h2e5, 12'hf00, 12'hfff, 12'h07d, 12'hf01, 12'h000, 12'h07e};

   logic        mclk, reset_n, reg_wr, reg_rd, reg_rvalid, bright_wr, shut_wr, gain_wr;
   logic        depth16, sw_trigger, trig_active, trig_start, fb, fs, fg, ft;
   logic [11:0] reg_addr, bright_value, shut_value, gain_value;
   logic [31:0] reg_wdata, reg_rdata;
   logic [3:0]  trig_pin, exposure_scheme;
   int          mismatches, total_checks;

   tcff_top #(.BRIGHT_MIN(BMIN), .BRIGHT_MAX(BMAX)) dut (.MCLK(mclk), .RESET_N(reset_n),
      .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .BRIGHT_WR(bright_wr),
      .BRIGHT_VALUE(bright_value), .SHUT_WR(shut_wr), .SHUT_VALUE(shut_value),
      .GAIN_WR(gain_wr), .GAIN_VALUE(gain_value), .PIXEL_DEPTH16(depth16),
      .TRIG_PIN(trig_pin), .SW_TRIGGER(sw_trigger), .TRIG_ACTIVE(trig_active),
      .TRIG_START(trig_start), .EXPOSURE_SCHEME(exposure_scheme));
   tcff_host host (.MCLK(mclk), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
      .TRIG_PIN(trig_pin), .SW_TRIGGER(sw_trigger));

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   function automatic logic [31:0] trg_word(input logic p, input logic [2:0] s,
                                            input logic [3:0] m);
      // present and on bits are fixed high
      trg_word = 32'h8200_0000 | {7'h00, p, s, 1'b0, m, 16'h0000};
   endfunction

   function automatic logic [31:0] flt_word();
      flt_word = {fb, 6'h00, fs, fg, 3'h0, ft, 19'h00000};
   endfunction

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      // an unknown outcome counts as a mismatch, never as a pass
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic rd_cmp(input logic [11:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] d;
      logic        ok;
      host.rd(a, d, ok);
      chk(ok === 1'b1 && d === exp, msg);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic trig_try(input logic [31:0] cfg, input logic [3:0] mask, input logic s,
                           input logic exp);
      logic [3:0] idle;
      int         n;
      idle = {4{~cfg[TRG_POL_POS]}};
      host.pins(idle);
      host.sw(1'b0);
      host.wr(TRIG_CFG_OFS, cfg);
      repeat (6) @(posedge mclk);
      host.pins(idle ^ mask);
      host.sw(s);
      for (n = 0; n < 8 && trig_active !== 1'b1; n++)
         @(posedge mclk);
      chk(trig_active === exp && trig_start === exp, "trigger response");
      if (exp && n == 8)
         print_verdict();
   endtask

   initial
   begin
      logic [31:0] wd;
      logic [11:0] v;
      logic        dp;
      int          w;
      reset_n = 1'b0;
      {bright_wr, shut_wr, gain_wr, depth16, fb, fs, fg, ft} = 8'h00;
      {bright_value, shut_value, gain_value} = 36'h0;
      mismatches = 0;
      total_checks = 0;
      void'($urandom(32'h2f5739a6));
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rd_cmp(TRIG_CFG_OFS, trg_word(1'b1, 3'h0, 4'h1), "trigger reset");
      rd_cmp(FAULT_HI_OFS, 32'h0, "fault reset");
      chk(exposure_scheme === 4'h1, "scheme reset");
      $display("test reset done");
      for (int i = 0; i < 24; i++)
      begin
         wd = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : (i == 2) ? 32'h00e1_0000 : $urandom;
         ft = (wd[23:21] inside {3'h4, 3'h5, 3'h6}) || wd[19:16] > 4'h1
              || (wd[23:21] == 3'h7 && wd[19:16] != 4'h0);
         host.wr(TRIG_CFG_OFS, wd);
         rd_cmp(FAULT_HI_OFS, flt_word(), "trigger fault");
         rd_cmp(TRIG_CFG_OFS, trg_word(wd[24], wd[23:21], wd[19:16]), "trigger word");
         chk(exposure_scheme === wd[19:16], "scheme output");
      end
      host.wr(FAULT_HI_OFS, 32'hffff_ffff);
      rd_cmp(FAULT_HI_OFS, flt_word(), "fault written");
      rd_cmp(12'h644, 32'h0, "unmapped read");
      $display("test trigger register done");
      for (int i = 0; i < 36; i++)
      begin
         w = i % 3;
         v = (i < 12) ? CORNER[i] : 12'($urandom);
         dp = (i < 12) ? (i >= 6) : 1'($urandom);
         depth16 <= dp;
         {bright_wr, shut_wr, gain_wr} <= 3'b100 >> w;
         {bright_value, shut_value, gain_value} <= {v, v, v};
         @(posedge mclk);
         {bright_wr, shut_wr, gain_wr} <= 3'b000;
         if (w == 0) fb = v < BMIN || v > BMAX;
         if (w == 1) fs = v < 12'h001;
         if (w == 2) fg = v > (dp ? 12'h07d : 12'h2e4);
         // software looks at the flag after every feature write it makes
         rd_cmp(FAULT_HI_OFS, flt_word(), "feature flags");
      end
      $display("test feature flags done");
      for (int p = 0; p < 2; p++)
         for (int k = 0; k < 4; k++)
         begin
            trig_try(trg_word(p[0], k[2:0], 4'h1), 4'(1 << ((k + 1) % 4)), 1'b0, 1'b0);
            trig_try(trg_word(p[0], k[2:0], 4'h0), 4'(1 << k), 1'b0, 1'b1);
         end
      trig_try(trg_word(1'b1, 3'h7, 4'h0), 4'h0, 1'b1, 1'b1);
      trig_try(trg_word(1'b0, 3'h7, 4'h1), 4'hf, 1'b1, 1'b1);
      trig_try(trg_word(1'b1, 3'h4, 4'h1), 4'hf, 1'b1, 1'b0);
      $display("test trigger path done");
      print_verdict();
   end
endmodule
